/* File: src/loop_sup_pkg.sv */
// constants, enums and timing counts shared by the loop supervisor files
// assumes a single 25 MHz core clock
package loop_sup_pkg;
   // ==================================================================
   // clock and timing
   localparam int CLK_HZ = 25_000_000;
   localparam int HEARTBEAT_MS = 100;
   localparam int HEARTBEAT_CYC = CLK_HZ / 1000 * HEARTBEAT_MS;
   localparam int SECOND_MS = 1000;
   localparam int SECOND_CYC = CLK_HZ / 1000 * SECOND_MS;
   localparam int LOGIC_CYCLE_MS = 100;
   localparam int LOGIC_CYCLE_CYC = CLK_HZ / 1000 * LOGIC_CYCLE_MS;
   localparam int NODE_TIMEOUT_MULT = 3;
   // ==================================================================
   // sizes
   localparam int NUM_NODES = 16;
   localparam int CTRL_FAULTS = 10;
   localparam int NODE_FAULTS = 23;
   localparam int NUM_ALARMS = 8;
   localparam int LOG_DEPTH = 4095;
   localparam int LOG_AW = 12;
   localparam int LOG_W = 16;
   localparam int PAGE_W = 8;
   // ==================================================================
   // controller fault bit positions
   localparam int CF_CONTROLLER = 0;
   localparam int CF_OFFLINE = 1;
   localparam int CF_EXTRA = 2;
   localparam int CF_CONFIG = 3;
   localparam int CF_RING = 4;
   localparam int CF_GROUND = 5;
   localparam int CF_PWR1 = 6;
   localparam int CF_PWR2 = 7;
   localparam int CF_RTC = 8;
   localparam int CF_REDUND = 9;
   // ==================================================================
   // event codes in the log (upper bits of an entry)
   localparam logic [3:0] EV_FAULT = 4'h1;
   localparam logic [3:0] EV_ALARM = 4'h2;
   localparam logic [3:0] EV_RESET = 4'h3;
   // reset values
   localparam logic [15:0] YEAR_RESET = 16'h0000;
   typedef enum logic [1:0] {HB_IDLE, HB_FWD, HB_REV} hb_e;
   typedef enum logic [1:0] {SCH_WAIT, SCH_RUN, SCH_DONE} sch_e;
endpackage : loop_sup_pkg

/* File: src/logic_scheduler.sv */
// user logic scheduler: paces logic page execution in fixed cycles
// assumes an external page engine that acknowledges each page run
`timescale 1ns/1ps
`default_nettype none
module logic_scheduler
   import loop_sup_pkg::*;
#(
   parameter int CYCLE_CYC = loop_sup_pkg::LOGIC_CYCLE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [loop_sup_pkg::PAGE_W-1:0] last_page,
   input wire logic page_done,
   output logic page_start,
   output logic [loop_sup_pkg::PAGE_W-1:0] page_index,
   output logic pass_complete
);
   import loop_sup_pkg::*;
   typedef struct packed {
      logic [31:0] tick;
      sch_e st;
      logic [PAGE_W-1:0] page;
      logic busy;
      logic done;
   } sched_s;
   sched_s q, d;
   logic cycle_edge;

   assign cycle_edge = (q.tick == 32'(CYCLE_CYC - 1));

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.tick = cycle_edge ? 32'h0 : q.tick + 32'h1;
      unique case (q.st)
         SCH_WAIT: begin
            if (cycle_edge) begin
               d.st = SCH_RUN;
               d.busy = 1'b1;
            end
         end
         SCH_RUN: begin
            if (cycle_edge && !q.busy) begin
               d.busy = 1'b1;
            end
            if (page_done) begin
               if (q.page == last_page) begin
                  d.st = SCH_WAIT;
                  d.page = '0;
                  d.busy = 1'b0;
                  d.done = 1'b1;
               end else begin
                  d.page = q.page + 1'b1;
                  // a pass longer than one cycle runs on into the next
               end
            end
         end
         default: begin
            d.st = SCH_WAIT;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= '{tick: 32'h0, st: SCH_WAIT, page: '0, busy: 1'b0,
                done: 1'b0};
      end else begin
         q <= d;
      end
   end

   // unfinished pages resume; restart only at a cycle start
   assign page_start = (q.st == SCH_RUN) && q.busy;
   assign page_index = q.page;
   assign pass_complete = q.done;

   a_restart_at_edge: assert property (@(posedge core_clk) disable iff (rst)
      (q.st == SCH_WAIT && !cycle_edge) |=> q.st == SCH_WAIT)
      else $error("scheduler left wait off a cycle boundary");
   a_page_order: assert property (@(posedge core_clk) disable iff (rst)
      (q.st == SCH_RUN && page_done && q.page != last_page)
      |=> q.page == $past(q.page) + 1'b1)
      else $error("logic page did not advance by one");
endmodule : logic_scheduler
`default_nettype wire

/* File: src/event_log.sv */
// alarm and event log memory with a serial-side read port
// assumes the read address comes from the configuration port logic
`timescale 1ns/1ps
`default_nettype none
module event_log
   import loop_sup_pkg::*;
#(
   parameter int DEPTH = loop_sup_pkg::LOG_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [loop_sup_pkg::LOG_W-1:0] wr_data,
   input wire logic [loop_sup_pkg::LOG_AW-1:0] rd_addr,
   output logic [loop_sup_pkg::LOG_W-1:0] rd_data,
   output logic [loop_sup_pkg::LOG_AW-1:0] count
);
   import loop_sup_pkg::*;
   typedef struct packed {
      logic [LOG_AW-1:0] wp;
      logic [LOG_AW-1:0] cnt;
      logic [LOG_W-1:0] rd;
   } log_s;
   log_s q, d;
   logic [LOG_W-1:0] mem [DEPTH];

   always_comb begin
      d = q;
      d.rd = mem[rd_addr];
      if (wr_en) begin
         // oldest entry is overwritten once the log is full
         d.wp = (q.wp == LOG_AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
         if (q.cnt != LOG_AW'(DEPTH)) begin
            d.cnt = q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[q.wp] <= wr_data;
      end
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rd_data = q.rd;
   assign count = q.cnt;

   a_log_bound: assert property (@(posedge core_clk) disable iff (rst)
      (wr_en && q.cnt != LOG_AW'(DEPTH)) |=> q.cnt == $past(q.cnt) + 1'b1)
      else $error("log count did not follow a write");
endmodule : event_log
`default_nettype wire

/* File: src/loop_supervisor.sv */
// loop supervision annunciator: heartbeat, ring check, fault latch, log
// assumes ring ports are framed elsewhere; one pulse per heartbeat frame
`timescale 1ns/1ps
`default_nettype none
module loop_supervisor
   import loop_sup_pkg::*;
#(
   parameter int HB_CYC = loop_sup_pkg::HEARTBEAT_CYC,
   parameter int SEC_CYC = loop_sup_pkg::SECOND_CYC,
   parameter int LOGIC_CYC = loop_sup_pkg::LOGIC_CYCLE_CYC,
   parameter int NODES = loop_sup_pkg::NUM_NODES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [31:0] time_date,
   input wire logic hb_rx_a,
   input wire logic hb_rx_b,
   input wire logic [NODES-1:0] node_configured,
   input wire logic [NODES-1:0] node_report,
   input wire logic [NODES-1:0][1:0] node_interval_s,
   input wire logic [loop_sup_pkg::NODE_FAULTS-1:0] node_fault_in,
   input wire logic [loop_sup_pkg::CTRL_FAULTS-1:0] ctrl_fault_in,
   input wire logic [loop_sup_pkg::NUM_ALARMS-1:0] alarm_in,
   input wire logic redundant_pair,
   input wire logic reset_button,
   input wire logic [loop_sup_pkg::LOG_AW-1:0] log_rd_addr,
   input wire logic [loop_sup_pkg::PAGE_W-1:0] last_page,
   input wire logic page_done,
   output logic hb_tx_a,
   output logic hb_tx_b,
   output logic hb_has_time,
   output logic [31:0] hb_time,
   output logic [loop_sup_pkg::CTRL_FAULTS-1:0] ctrl_fault_shown,
   output logic [loop_sup_pkg::NODE_FAULTS-1:0] node_fault_shown,
   output logic [NODES-1:0] node_offline_shown,
   output logic [loop_sup_pkg::NUM_ALARMS-1:0] alarm_shown,
   output logic trouble_led,
   output logic ring_fault_led,
   output logic trouble_relay_energized,
   output logic trouble_tone,
   output logic alarm_tone,
   output logic reset_accepted,
   output logic [loop_sup_pkg::LOG_W-1:0] log_rd_data,
   output logic [loop_sup_pkg::LOG_AW-1:0] log_count,
   output logic page_start,
   output logic [loop_sup_pkg::PAGE_W-1:0] page_index,
   output logic pass_complete
);
   import loop_sup_pkg::*;

   // ==================================================================
   // state
   typedef struct packed {
      logic [31:0] hb_tick;
      logic [31:0] sec_tick;
      hb_e hb_st;
      logic tx_a;
      logic tx_b;
      logic has_time;
      logic [31:0] tm;
      logic wait_a;
      logic wait_b;
      logic ring_fault;
      logic [CTRL_FAULTS-1:0] cf;
      logic [NODE_FAULTS-1:0] nf;
      logic [NUM_ALARMS-1:0] al;
      logic [NODES-1:0] off;
      logic [NODES-1:0][31:0] age;
      logic btn;
      logic acc;
      logic log_we;
      logic [LOG_W-1:0] log_wd;
   } sup_s;
   sup_s q, d;

   logic [CTRL_FAULTS-1:0] cf_now;
   logic [NODES-1:0] late;
   logic any_active;
   logic any_shown;
   logic hb_edge;
   logic sec_edge;
   logic press;

   // ==================================================================
   // per node reporting watchdog
   genvar gi;
   generate
      for (gi = 0; gi < NODES; gi++) begin : g_node
         logic [31:0] limit;
         assign limit = 32'(NODE_TIMEOUT_MULT * SEC_CYC)
            * {30'h0, node_interval_s[gi]};
         assign late[gi] = node_configured[gi] && (q.age[gi] >= limit)
            && (node_interval_s[gi] != 2'h0);
      end
   endgenerate

   assign hb_edge = (q.hb_tick == 32'(HB_CYC - 1));
   assign sec_edge = (q.sec_tick == 32'(SEC_CYC - 1));
   assign press = reset_button && !q.btn;

   always_comb begin
      cf_now = ctrl_fault_in;
      cf_now[CF_RING] = q.ring_fault;
      cf_now[CF_OFFLINE] = ctrl_fault_in[CF_OFFLINE] || (|late);
      cf_now[CF_REDUND] = ctrl_fault_in[CF_REDUND] && redundant_pair;
   end

   assign any_active = (|cf_now) || (|node_fault_in) || (|alarm_in)
      || (|late);
   assign any_shown = (|q.cf) || (|q.nf) || (|q.al) || (|q.off);

   // ==================================================================
   // next state
   always_comb begin
      d = q;
      d.tx_a = 1'b0;
      d.tx_b = 1'b0;
      d.acc = 1'b0;
      d.log_we = 1'b0;
      d.log_wd = q.log_wd;
      d.btn = reset_button;
      d.hb_tick = hb_edge ? 32'h0 : q.hb_tick + 32'h1;
      d.sec_tick = sec_edge ? 32'h0 : q.sec_tick + 32'h1;
      if (sec_edge) begin
         d.has_time = 1'b1;
         d.tm = time_date;
      end
      // heartbeat: forward frame then reverse frame each period
      unique case (q.hb_st)
         HB_IDLE: begin
            if (hb_edge) begin
               d.hb_st = HB_FWD;
            end
         end
         HB_FWD: begin
            d.tx_a = 1'b1;
            // a loop still awaiting return at send time is broken
            if (q.wait_b) begin
               d.ring_fault = 1'b1;
            end
            d.wait_b = 1'b1;
            d.hb_st = HB_REV;
         end
         HB_REV: begin
            d.tx_b = 1'b1;
            if (q.wait_a) begin
               d.ring_fault = 1'b1;
            end
            d.wait_a = 1'b1;
            d.hb_st = HB_IDLE;
         end
         default: begin
            d.hb_st = HB_IDLE;
         end
      endcase
      if (hb_rx_b) begin
         d.wait_b = 1'b0;
      end
      if (hb_rx_a) begin
         d.wait_a = 1'b0;
      end
      // both returns in one cycle, nothing left pending, heals the ring
      if (hb_rx_a && hb_rx_b && !d.wait_a && !d.wait_b) begin
         d.ring_fault = 1'b0;
      end
      for (int i = 0; i < NODES; i++) begin
         if (node_report[i] || !node_configured[i]) begin
            d.age[i] = 32'h0;
         end else if (!late[i]) begin
            d.age[i] = q.age[i] + 32'h1;
         end
      end
      // reset clears latches, then live conditions set again (set wins)
      if (press && !any_active) begin
         d.acc = 1'b1;
         d.cf = '0;
         d.nf = '0;
         d.al = '0;
         d.off = '0;
         d.log_we = 1'b1;
         d.log_wd = {EV_RESET, 12'h000};
      end
      d.cf = d.cf | cf_now;
      d.nf = d.nf | node_fault_in;
      d.al = d.al | alarm_in;
      d.off = d.off | late;
      if ((|(alarm_in & ~q.al)) && !d.log_we) begin
         d.log_we = 1'b1;
         d.log_wd = {EV_ALARM, 4'h0, 8'(alarm_in)};
      end else if ((|(cf_now & ~q.cf)) && !d.log_we) begin
         d.log_we = 1'b1;
         d.log_wd = {EV_FAULT, 2'h0, cf_now};
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ==================================================================
   // annunciation
   assign hb_tx_a = q.tx_a;
   assign hb_tx_b = q.tx_b;
   assign hb_has_time = q.has_time;
   assign hb_time = q.tm;
   assign ctrl_fault_shown = q.cf;
   assign node_fault_shown = q.nf;
   assign node_offline_shown = q.off;
   assign alarm_shown = q.al;
   assign trouble_led = (|q.cf) || (|q.nf) || (|q.off);
   assign ring_fault_led = q.cf[CF_RING];
   assign trouble_relay_energized = !trouble_led;
   assign trouble_tone = trouble_led;
   assign alarm_tone = |q.al;
   assign reset_accepted = q.acc;

   event_log u_log (
      .core_clk(core_clk),
      .rst(rst),
      .wr_en(q.log_we),
      .wr_data(q.log_wd),
      .rd_addr(log_rd_addr),
      .rd_data(log_rd_data),
      .count(log_count)
   );

   logic_scheduler #(.CYCLE_CYC(LOGIC_CYC)) u_sched (
      .core_clk(core_clk),
      .rst(rst),
      .last_page(last_page),
      .page_done(page_done),
      .page_start(page_start),
      .page_index(page_index),
      .pass_complete(pass_complete)
   );

   // ==================================================================
   // checks
   a_hb_period: assert property (@(posedge core_clk) disable iff (rst)
      hb_edge |-> ##2 hb_tx_a ##1 hb_tx_b)
      else $error("heartbeat frames not sent in order");
   a_redund_gate: assert property (@(posedge core_clk) disable iff (rst)
      (!redundant_pair && !$past(redundant_pair) && !q.acc)
      |-> $stable(q.cf[CF_REDUND]) || q.cf[CF_REDUND] == 1'b0)
      else $error("redundancy fault without redundant pair");
   a_ring_led: assert property (@(posedge core_clk) disable iff (rst)
      ring_fault_led |-> trouble_led && !trouble_relay_energized)
      else $error("ring led without trouble");
   a_latch_hold: assert property (@(posedge core_clk) disable iff (rst)
      (trouble_led && !d.acc) |=> trouble_led)
      else $error("fault latch dropped without reset");
   a_reset_gate: assert property (@(posedge core_clk) disable iff (rst)
      (reset_button && !q.btn && any_active) |=> !reset_accepted)
      else $error("reset accepted with active condition");
   a_alarm_keep: assert property (@(posedge core_clk) disable iff (rst)
      alarm_in[0] |=> alarm_shown[0])
      else $error("active alarm not shown");
   a_ring_return: assert property (@(posedge core_clk) disable iff (rst)
      (q.hb_st == HB_FWD && q.wait_b) |=> q.ring_fault)
      else $error("missed return did not raise ring fault");
   a_node_late: assert property (@(posedge core_clk) disable iff (rst)
      (|late) |=> ((node_offline_shown & $past(late)) == $past(late))
      && trouble_led)
      else $error("late node not shown offline");
endmodule : loop_supervisor
`default_nettype wire

/* File: testbench/ring_node_model.sv */
// =============================================================
// ring side model: loops heartbeats back, field nodes report
// assumes one-cycle heartbeat pulses on hb_tx_a and hb_tx_b
`timescale 1ns/1ps
`default_nettype none
module ring_node_model #(
   parameter int NODES = 16,
   parameter int SEC_CYC = 50,
   parameter int HB_CYC = 20,
   parameter int DLY = 4,
   parameter int ISO_LIMIT = 2000
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hb_tx_a,
   input wire logic hb_tx_b,
   input wire logic ring_break,
   input wire logic [NODES-1:0] mute,
   output logic hb_rx_a,
   output logic hb_rx_b,
   output logic [NODES-1:0] node_report
);
   // forward path one stage longer so both returns land together
   logic [DLY:0] fwd_q;
   logic [DLY-1:0] rev_q;
   int rep_cnt;
   int lost_cnt;
   int iso_cnt;
   logic iso_on;
   logic iso_side;
   logic hb_seen;
   assign hb_seen = (hb_tx_a | hb_tx_b) & ~ring_break;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fwd_q <= '0;
         rev_q <= '0;
         rep_cnt <= 0;
         lost_cnt <= 0;
         iso_cnt <= 0;
         iso_on <= 1'b0;
         iso_side <= 1'b0;
      end else begin
         fwd_q <= {fwd_q[DLY-1:0], hb_tx_a & ~ring_break};
         rev_q <= {rev_q[DLY-2:0], hb_tx_b & ~ring_break};
         rep_cnt <= (rep_cnt == SEC_CYC - 1) ? 0 : rep_cnt + 1;
         if (hb_seen) begin
            // heartbeat back: isolation re-armed, relays closed
            lost_cnt <= 0;
            iso_cnt <= 0;
            iso_on <= 1'b0;
         end else begin
            lost_cnt <= lost_cnt + 1;
            if (lost_cnt == 3 * HB_CYC && iso_cnt < ISO_LIMIT) begin
               iso_on <= 1'b1;
            end
            if (iso_on) begin
               iso_cnt <= iso_cnt + 1;
               if (iso_cnt % HB_CYC == 0) begin
                  iso_side <= ~iso_side;
               end
               if (iso_cnt == ISO_LIMIT) begin
                  iso_on <= 1'b0;
               end
            end
         end
      end
   end
   assign hb_rx_b = fwd_q[DLY];
   assign hb_rx_a = rev_q[DLY-1];
   // isolating nodes cannot reach the supervisor, so they stay quiet
   assign node_report = (rep_cnt == 0 && !iso_on && !rst) ? ~mute : '0;
endmodule : ring_node_model
`default_nettype wire

/* File: testbench/loop_supervision_annunciator_tb_top.sv */
// =============================================================
// self-checking bench for the loop supervisor
// assumes shortened heartbeat, second and logic cycle counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; \
   if ((got) !== (exp)) begin n_fail++; \
   $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
module loop_supervision_annunciator_tb_top;
   import loop_sup_pkg::*;
   localparam int HB = 20;
   localparam int SEC = 50;
   localparam int LGC = 30;
   localparam int N = 16;
   logic core_clk, rst, hb_rx_a, hb_rx_b, redundant_pair, reset_button;
   logic page_done, ring_break, hb_tx_a, hb_tx_b, hb_has_time;
   logic trouble_led, ring_fault_led, trouble_relay_energized;
   logic trouble_tone, alarm_tone, reset_accepted, page_start;
   logic pass_complete;
   logic [31:0] time_date, hb_time;
   logic [N-1:0] node_configured, node_report, mute, node_offline_shown;
   logic [N-1:0][1:0] node_interval_s;
   logic [NODE_FAULTS-1:0] node_fault_in, node_fault_shown;
   logic [CTRL_FAULTS-1:0] ctrl_fault_in, ctrl_fault_shown;
   logic [NUM_ALARMS-1:0] alarm_in, alarm_shown;
   logic [LOG_AW-1:0] log_rd_addr, log_count, c0;
   logic [LOG_W-1:0] log_rd_data;
   logic [PAGE_W-1:0] last_page, page_index;
   int n_fail = 0;
   int check_count = 0;
   int cycles = 0;
   loop_supervisor #(.HB_CYC(HB), .SEC_CYC(SEC), .LOGIC_CYC(LGC),
      .NODES(N)) dut_u (.core_clk(core_clk), .rst(rst),
      .time_date(time_date), .hb_rx_a(hb_rx_a), .hb_rx_b(hb_rx_b),
      .node_configured(node_configured), .node_report(node_report),
      .node_interval_s(node_interval_s), .node_fault_in(node_fault_in),
      .ctrl_fault_in(ctrl_fault_in), .alarm_in(alarm_in),
      .redundant_pair(redundant_pair), .reset_button(reset_button),
      .log_rd_addr(log_rd_addr), .last_page(last_page),
      .page_done(page_done), .hb_tx_a(hb_tx_a), .hb_tx_b(hb_tx_b),
      .hb_has_time(hb_has_time), .hb_time(hb_time),
      .ctrl_fault_shown(ctrl_fault_shown),
      .node_fault_shown(node_fault_shown),
      .node_offline_shown(node_offline_shown), .alarm_shown(alarm_shown),
      .trouble_led(trouble_led), .ring_fault_led(ring_fault_led),
      .trouble_relay_energized(trouble_relay_energized),
      .trouble_tone(trouble_tone), .alarm_tone(alarm_tone),
      .reset_accepted(reset_accepted), .log_rd_data(log_rd_data),
      .log_count(log_count), .page_start(page_start),
      .page_index(page_index), .pass_complete(pass_complete));
   ring_node_model #(.NODES(N), .SEC_CYC(SEC), .HB_CYC(HB)) node_u (
      .core_clk(core_clk), .rst(rst), .hb_tx_a(hb_tx_a),
      .hb_tx_b(hb_tx_b), .ring_break(ring_break), .mute(mute),
      .hb_rx_a(hb_rx_a), .hb_rx_b(hb_rx_b), .node_report(node_report));
   // =============================================================
   // clock, timeout and report
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   // whole run needs about 1100 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 12000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // =============================================================
   // helpers
   task automatic press_reset(input logic ok);
      logic seen;
      seen = 1'b0;
      @(negedge core_clk) reset_button = 1'b1;
      repeat (4) @(negedge core_clk) seen = seen | reset_accepted;
      reset_button = 1'b0;
      `CHK("reset_accepted", ok, seen)
   endtask : press_reset
   task automatic wait_hb(output int n);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (hb_tx_a !== 1'b1 && n < 200);
   endtask : wait_hb
   // =============================================================
   // scenarios
   task automatic t_heartbeat();
      int n;
      wait_hb(n);
      @(negedge core_clk);
      `CHK("hb_tx_b", 1'b1, hb_tx_b)
      wait_hb(n);
      `CHK("hb_period", HB - 1, n)
      `CHK("ring_led_intact", 1'b0, ring_fault_led)
   endtask : t_heartbeat
   task automatic t_time();
      time_date = 32'hC0FF_EE01;
      repeat (2 * SEC + 5) @(negedge core_clk);
      `CHK("hb_has_time", 1'b1, hb_has_time)
      `CHK("hb_time", time_date, hb_time)
   endtask : t_time
   task automatic t_faults();
      logic exp;
      c0 = log_count;
      ctrl_fault_in[CF_CONTROLLER] = 1'b1;
      repeat (3) @(negedge core_clk);
      ctrl_fault_in = '0;
      repeat (3) @(negedge core_clk);
      `CHK("ctrl_latched", 1'b1, ctrl_fault_shown[CF_CONTROLLER])
      `CHK("relay", 1'b0, trouble_relay_energized)
      `CHK("trouble_tone", 1'b1, trouble_tone)
      `CHK("log_count", c0 + 12'h001, log_count)
      log_rd_addr = c0;
      repeat (2) @(negedge core_clk);
      `CHK("log_code", EV_FAULT, log_rd_data[15:12])
      press_reset(1'b1);
      `CHK("ctrl_cleared", 1'b0, ctrl_fault_shown)
      `CHK("relay_back", 1'b1, trouble_relay_energized)
      for (int r = 0; r < 2; r++) begin
         redundant_pair = r[0];
         for (int i = 0; i < CTRL_FAULTS; i++) begin
            if (i == CF_RING || (r == 1 && i != CF_REDUND)) continue;
            exp = (i != CF_REDUND) || r == 1;
            ctrl_fault_in[i] = 1'b1;
            repeat (3) @(negedge core_clk);
            ctrl_fault_in = '0;
            `CHK("ctrl_shown", exp, ctrl_fault_shown[i])
            `CHK("trouble_led", exp, trouble_led)
            `CHK("ring_led", 1'b0, ring_fault_led)
            press_reset(1'b1);
         end
      end
      redundant_pair = 1'b0;
      for (int j = 0; j < NODE_FAULTS; j++) begin
         node_fault_in[j] = 1'b1;
         repeat (3) @(negedge core_clk);
         node_fault_in = '0;
         `CHK("node_shown", 1'b1, node_fault_shown[j])
         `CHK("relay_node", 1'b0, trouble_relay_energized)
         press_reset(1'b1);
      end
   endtask : t_faults
   task automatic t_ring_break();
      ring_break = 1'b1;
      repeat (3 * HB) @(negedge core_clk);
      `CHK("ring_shown", 1'b1, ctrl_fault_shown[CF_RING])
      `CHK("ring_led", 1'b1, ring_fault_led)
      `CHK("ring_tone", 1'b1, trouble_tone)
      press_reset(1'b0);
      ring_break = 1'b0;
      repeat (3 * HB) @(negedge core_clk);
      `CHK("ring_latched", 1'b1, ring_fault_led)
      press_reset(1'b1);
      `CHK("ring_led_off", 1'b0, ring_fault_led)
   endtask : t_ring_break
   task automatic t_alarms();
      for (int k = 0; k < NUM_ALARMS; k++) begin
         alarm_in[k] = 1'b1;
         repeat (3) @(negedge core_clk);
         alarm_in = '0;
         `CHK("alarm_shown", 1'b1, alarm_shown[k])
         `CHK("alarm_tone", 1'b1, alarm_tone)
         press_reset(1'b1);
      end
      alarm_in[5] = 1'b1;
      repeat (3) @(negedge core_clk);
      press_reset(1'b0);
      `CHK("alarm_kept", 1'b1, alarm_shown[5])
      alarm_in = '0;
      press_reset(1'b1);
      `CHK("alarm_gone", 1'b0, alarm_shown)
   endtask : t_alarms
   task automatic t_offline();
      mute[2] = 1'b1;
      repeat (5 * SEC) @(negedge core_clk);
      `CHK("node2_offline", 1'b1, node_offline_shown[2])
      `CHK("node1_online", 1'b0, node_offline_shown[1])
      `CHK("offline_trouble", 1'b1, trouble_led)
      press_reset(1'b0);
      mute = '0;
      repeat (2 * SEC) @(negedge core_clk);
      press_reset(1'b1);
      `CHK("offline_clear", 1'b0, node_offline_shown)
   endtask : t_offline
   task automatic t_sched();
      int n;
      last_page = 8'h02;
      n = 0;
      while (page_start !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      `CHK("first_page", 8'h00, page_index)
      for (int p = 0; p < 3; p++) begin
         @(negedge core_clk) page_done = 1'b1;
         @(negedge core_clk) page_done = 1'b0;
         if (p < 2) `CHK("page_next", p[7:0] + 8'h01, page_index)
         else `CHK("pass_done", 1'b1, pass_complete)
      end
      `CHK("idle_after_pass", 1'b0, page_start)
      n = 0;
      while (page_start !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      `CHK("cycle_start", 1'b1, n <= LGC)
      `CHK("restart_page", 8'h00, page_index)
      @(negedge core_clk) page_done = 1'b1;
      @(negedge core_clk) page_done = 1'b0;
      repeat (LGC + 2) @(negedge core_clk);
      `CHK("resume_page", 8'h01, page_index)
   endtask : t_sched
   // =============================================================
   // main sequence
   initial begin
      rst = 1'b1;
      time_date = 32'h0000_0001;
      node_configured = 16'h000F;
      node_interval_s = {N{2'h1}};
      node_fault_in = '0;
      ctrl_fault_in = '0;
      alarm_in = '0;
      redundant_pair = 1'b0;
      reset_button = 1'b0;
      log_rd_addr = '0;
      last_page = 8'h02;
      page_done = 1'b0;
      ring_break = 1'b0;
      mute = '0;
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      t_heartbeat();
      t_time();
      t_faults();
      t_ring_break();
      t_alarms();
      t_offline();
      t_sched();
      tally_and_finish();
   end
endmodule : loop_supervision_annunciator_tb_top
`default_nettype wire
